/* adc_mux_pkg.sv */
// Constants and types for the converter input path control
package adc_mux_pkg;

    // ----------------------------------------------------------------
    // Register addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] converter_control_addr = 8'hB8;
    localparam logic [7:0] converter_configuration_addr = 8'hB9;
    localparam logic [7:0] input_pair_configuration_addr = 8'hBA;
    localparam logic [7:0] channel_select_addr = 8'hBB;
    localparam logic [7:0] port_pin_analog_select_addr = 8'hBD;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int converter_enable_pos = 7;
    localparam int done_flag_pos = 5;
    localparam int start_busy_pos = 4;
    localparam int port_pair_diff_pos = 3;
    localparam int hv_amp_diff_pos = 2;
    localparam int inputs_two_three_diff_pos = 1;
    localparam int inputs_zero_one_diff_pos = 0;
    localparam int temp_select_pos = 3;
    localparam logic [3:0] pair_config_reset = 4'h0;
    localparam logic [3:0] channel_select_reset = 4'h0;
    localparam logic [7:0] port_pin_reset = 8'h00;
    localparam int result_width = 12;
    localparam int port_pin_count = 8;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        gain_unity = 3'h0,
        gain_two = 3'h1,
        gain_four = 3'h2,
        gain_eight = 3'h3,
        gain_sixteen = 3'h4,
        gain_half = 3'h6
    } gain_type;

    localparam gain_type gain_reset = gain_unity;

    typedef enum logic [3:0] {
        src_ain0, src_ain1, src_ain2, src_ain3, src_hv_amp, src_hv_ref,
        src_agnd, src_port_even, src_port_odd, src_temp
    } source_type;

    typedef struct packed {
        source_type pos;
        source_type neg;
        logic diff;
    } mux_select_type;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } sfr_request_type;

endpackage : adc_mux_pkg

/* adc_input_mux_config.sv */
// Input multiplexer, gain and result format control for the converter
`timescale 1ns/100ps
module adc_input_mux_config (
    input wire logic clk,
    input wire logic reset,
    input adc_mux_pkg::sfr_request_type sfr,
    output logic [7:0] sfr_rdata_q,
    output logic sfr_read_valid_q,
    input wire logic conv_done,
    input wire logic [11:0] conv_raw,
    output logic subsystem_on_q,
    output logic conv_start_q,
    output adc_mux_pkg::mux_select_type route_q,
    output adc_mux_pkg::gain_type gain_q,
    output logic [3:0] even_pins_q,
    output logic [3:0] odd_pins_q,
    output logic even_wired_or_q,
    output logic odd_wired_or_q,
    output logic [11:0] result_q,
    output logic result_valid_q
);
    import adc_mux_pkg::*;

    // ----------------------------------------------------------------
    // Channel routing
    // ----------------------------------------------------------------
    function automatic mux_select_type route_of(input logic [3:0] ch, input logic [3:0] cf);
        mux_select_type r;
        r.pos = src_agnd;
        r.neg = src_agnd;
        r.diff = 1'b0;
        if (ch[temp_select_pos]) begin
            r.pos = src_temp;
        end else begin
            case (ch[2:0])
                3'h0, 3'h1: begin
                    if (cf[inputs_zero_one_diff_pos]) begin
                        r.pos = src_ain0;
                        r.neg = src_ain1;
                        r.diff = 1'b1;
                    end else begin
                        r.pos = ch[0] ? src_ain1 : src_ain0;
                    end
                end
                3'h2, 3'h3: begin
                    if (cf[inputs_two_three_diff_pos]) begin
                        r.pos = src_ain2;
                        r.neg = src_ain3;
                        r.diff = 1'b1;
                    end else begin
                        r.pos = ch[0] ? src_ain3 : src_ain2;
                    end
                end
                3'h4, 3'h5: begin
                    if (cf[hv_amp_diff_pos]) begin
                        r.pos = src_hv_amp;
                        r.neg = src_hv_ref;
                        r.diff = 1'b1;
                    end else begin
                        r.pos = ch[0] ? src_agnd : src_hv_amp;
                    end
                end
                default: begin
                    if (cf[port_pair_diff_pos]) begin
                        r.pos = src_port_even;
                        r.neg = src_port_odd;
                        r.diff = 1'b1;
                    end else begin
                        r.pos = ch[0] ? src_port_odd : src_port_even;
                    end
                end
            endcase
        end
        return r;
    endfunction : route_of

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic enable_q;
    logic busy_q;
    logic done_q;
    logic [3:0] pair_config_q;
    logic [3:0] channel_q;
    logic [7:0] pin_enable_q;
    gain_type gain_field_q;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    wire addr_control = sfr.addr == converter_control_addr;
    wire addr_config = sfr.addr == converter_configuration_addr;
    wire addr_pair = sfr.addr == input_pair_configuration_addr;
    wire addr_channel = sfr.addr == channel_select_addr;
    wire addr_pins = sfr.addr == port_pin_analog_select_addr;
    wire addr_mapped = addr_control || addr_config || addr_pair || addr_channel || addr_pins;

    wire wr_control = sfr.wr && addr_control;
    wire wr_config = sfr.wr && addr_config;
    wire wr_pair = sfr.wr && addr_pair;
    wire wr_channel = sfr.wr && addr_channel;
    wire wr_pins = sfr.wr && addr_pins;
    wire read_hit = sfr.rd && addr_mapped;

    // ----------------------------------------------------------------
    // Conversion control
    // ----------------------------------------------------------------
    wire enable_wr_bit = sfr.wdata[converter_enable_pos];
    wire start_wr_bit = sfr.wdata[start_busy_pos];
    wire done_wr_bit = sfr.wdata[done_flag_pos];
    wire enable_d = wr_control ? enable_wr_bit : enable_q;
    wire start_req = wr_control && start_wr_bit && enable_d && !busy_q;
    wire finish = busy_q && conv_done;
    wire result_take = finish && enable_d;
    wire done_clear = wr_control && !done_wr_bit;
    wire done_d = result_take || (done_q && !done_clear);
    wire busy_d = enable_d && (start_req || (busy_q && !conv_done));

    always_ff @(posedge clk) begin
        if (reset) begin
            enable_q <= 1'b0;
        end else begin
            enable_q <= enable_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= busy_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            done_q <= 1'b0;
        end else begin
            done_q <= done_d;
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    gain_type gain_wr;
    assign gain_wr = gain_type'(sfr.wdata[2:0]);
    wire gain_code_ok = (sfr.wdata[2:0] <= 3'h4) || (sfr.wdata[2:0] == 3'h6);

    wire [3:0] pair_config_d = wr_pair ? sfr.wdata[3:0] : pair_config_q;
    wire [3:0] channel_d = wr_channel ? sfr.wdata[3:0] : channel_q;
    wire [7:0] pin_enable_d = wr_pins ? sfr.wdata : pin_enable_q;
    gain_type gain_field_d;
    assign gain_field_d = (wr_config && gain_code_ok) ? gain_wr : gain_field_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            pair_config_q <= pair_config_reset;
        end else begin
            pair_config_q <= pair_config_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            channel_q <= channel_select_reset;
        end else begin
            channel_q <= channel_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pin_enable_q <= port_pin_reset;
        end else begin
            pin_enable_q <= pin_enable_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            gain_field_q <= gain_reset;
        end else begin
            gain_field_q <= gain_field_d;
        end
    end

    // ----------------------------------------------------------------
    // Register read-back
    // ----------------------------------------------------------------
    wire [7:0] control_view = {enable_q, 1'b0, done_q, busy_q, 4'h0};
    wire [7:0] config_view = {5'h00, gain_field_q};
    wire [7:0] pair_view = {4'h0, pair_config_q};
    wire [7:0] channel_view = {4'h0, channel_q};
    wire [7:0] read_mux =
        addr_control ? control_view :
        addr_config ? config_view :
        addr_pair ? pair_view :
        addr_channel ? channel_view :
        addr_pins ? pin_enable_q : 8'h00;
    wire [7:0] sfr_rdata_d = read_hit ? read_mux : 8'h00;

    always_ff @(posedge clk) begin
        if (reset) begin
            sfr_rdata_q <= 8'h00;
        end else begin
            sfr_rdata_q <= sfr_rdata_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sfr_read_valid_q <= 1'b0;
        end else begin
            sfr_read_valid_q <= read_hit;
        end
    end

    // ----------------------------------------------------------------
    // Port 3 pin routing
    // ----------------------------------------------------------------
    logic [3:0] even_pins_d;
    logic [3:0] odd_pins_d;

    genvar i;
    generate
        for (i = 0; i < port_pin_count / 2; i++) begin : g_pin
            assign even_pins_d[i] = pin_enable_q[2 * i];
            assign odd_pins_d[i] = pin_enable_q[2 * i + 1];
        end
    endgenerate

    wire even_short = (even_pins_d & (even_pins_d - 4'h1)) != 4'h0;
    wire odd_short = (odd_pins_d & (odd_pins_d - 4'h1)) != 4'h0;

    // ----------------------------------------------------------------
    // Conversion snapshot
    // ----------------------------------------------------------------
    mux_select_type live_route;
    assign live_route = route_of(channel_q, pair_config_q);
    wire snapshot_open = !busy_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            subsystem_on_q <= 1'b0;
        end else begin
            subsystem_on_q <= enable_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            conv_start_q <= 1'b0;
        end else begin
            conv_start_q <= start_req;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            route_q <= '{pos: src_ain0, neg: src_agnd, diff: 1'b0};
        end else if (snapshot_open) begin
            route_q <= live_route;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            gain_q <= gain_reset;
        end else if (snapshot_open) begin
            gain_q <= gain_field_q;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            even_pins_q <= 4'h0;
        end else if (snapshot_open) begin
            even_pins_q <= even_pins_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            odd_pins_q <= 4'h0;
        end else if (snapshot_open) begin
            odd_pins_q <= odd_pins_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            even_wired_or_q <= 1'b0;
        end else if (snapshot_open) begin
            even_wired_or_q <= even_short;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            odd_wired_or_q <= 1'b0;
        end else if (snapshot_open) begin
            odd_wired_or_q <= odd_short;
        end
    end

    // ----------------------------------------------------------------
    // Result formatting
    // ----------------------------------------------------------------
    wire [11:0] formatted = route_q.diff ? {~conv_raw[11], conv_raw[10:0]} : conv_raw;
    wire [11:0] result_d = result_take ? formatted : result_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            result_q <= 12'h000;
        end else begin
            result_q <= result_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            result_valid_q <= 1'b0;
        end else begin
            result_valid_q <= result_take;
        end
    end

endmodule : adc_input_mux_config

/* adc_input_mux_config_sva.sv */
// Assertion checker for the converter input path control
`timescale 1ns/100ps
module adc_input_mux_config_sva (
    input wire logic clk,
    input wire logic reset,
    input adc_mux_pkg::sfr_request_type sfr,
    input wire logic [7:0] sfr_rdata_q,
    input wire logic sfr_read_valid_q,
    input wire logic conv_done,
    input wire logic [11:0] conv_raw,
    input wire logic subsystem_on_q,
    input wire logic conv_start_q,
    input adc_mux_pkg::mux_select_type route_q,
    input adc_mux_pkg::gain_type gain_q,
    input wire logic [3:0] even_pins_q,
    input wire logic [3:0] odd_pins_q,
    input wire logic even_wired_or_q,
    input wire logic odd_wired_or_q,
    input wire logic [11:0] result_q,
    input wire logic result_valid_q
);
    import adc_mux_pkg::*;
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    a_pair_upper_zero: assert property (sfr.rd && sfr.addr == input_pair_configuration_addr |=>
        sfr_read_valid_q && sfr_rdata_q[7:4] == 4'h0) else $error("pair config upper bits not zero");
    a_start_when_on: assert property (conv_start_q |-> subsystem_on_q) else $error("start while off");
    a_start_one_pulse: assert property (conv_start_q |=> !conv_start_q) else $error("start not a pulse");
    a_result_cause: assert property (result_valid_q |-> $past(conv_done)) else $error("result without done");
    a_diff_format: assert property (result_valid_q && route_q.diff |->
        result_q == {~$past(conv_raw[11]), $past(conv_raw[10:0])}) else $error("diff result format");
    a_single_format: assert property (result_valid_q && !route_q.diff |->
        result_q == $past(conv_raw)) else $error("single result format");
    a_gain_legal: assert property (!(gain_q inside {3'h5, 3'h7})) else $error("illegal gain code");
    a_wired_or: assert property (even_wired_or_q == ($countones(even_pins_q) > 1) &&
        odd_wired_or_q == ($countones(odd_pins_q) > 1)) else $error("wired-or flag wrong");
    a_single_ground: assert property (!route_q.diff |-> route_q.neg == src_agnd)
        else $error("single-ended negative not ground");
    a_route_frozen: assert property (conv_start_q |=> $stable(route_q) && $stable(gain_q))
        else $error("route changed in conversion");
    a_temp_single: assert property (route_q.pos == src_temp |-> !route_q.diff) else $error("temp paired");
    c_diff_result: cover property (result_valid_q && route_q.diff);
    c_wired: cover property (even_wired_or_q);
    c_read: cover property (sfr_read_valid_q);
endmodule : adc_input_mux_config_sva

bind adc_input_mux_config adc_input_mux_config_sva chk_i (.clk(clk), .reset(reset), .sfr(sfr),
    .sfr_rdata_q(sfr_rdata_q), .sfr_read_valid_q(sfr_read_valid_q), .conv_done(conv_done), .conv_raw(conv_raw),
    .subsystem_on_q(subsystem_on_q), .conv_start_q(conv_start_q), .route_q(route_q), .gain_q(gain_q),
    .even_pins_q(even_pins_q), .odd_pins_q(odd_pins_q), .even_wired_or_q(even_wired_or_q),
    .odd_wired_or_q(odd_wired_or_q), .result_q(result_q), .result_valid_q(result_valid_q));

/* adc_input_mux_config_bench.sv */
// Self-checking bench for the converter input path control
`timescale 1ns/100ps
module adc_input_mux_config_bench;
    import adc_mux_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    sfr_request_type sfr = '0;
    logic conv_done = 1'b0;
    logic [11:0] conv_raw = 12'h000;
    logic [7:0] rdata_q;
    logic rvalid_q, on_q, start_q, ewor_q, owor_q, rsvalid_q;
    mux_select_type route_q;
    gain_type gain_q;
    logic [3:0] epins_q, opins_q;
    logic [11:0] result_q;
    int failures = 0;
    int checked = 0;
    logic [2:0] gcode [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    logic [2:0] gexp [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h6, 3'h6};
    logic [7:0] rcfg [12] = '{8'h01, 8'h01, 8'h02, 8'h00, 8'h04, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h0E, 8'h0F};
    logic [7:0] rch [12] = '{8'h00, 8'h01, 8'h03, 8'h03, 8'h04, 8'h04, 8'h07, 8'h09, 8'h05, 8'h06, 8'h01, 8'h05};
    mux_select_type rexp [12] = '{'{src_ain0, src_ain1, 1'b1}, '{src_ain0, src_ain1, 1'b1},
        '{src_ain2, src_ain3, 1'b1}, '{src_ain3, src_agnd, 1'b0}, '{src_hv_amp, src_hv_ref, 1'b1},
        '{src_hv_amp, src_agnd, 1'b0}, '{src_port_even, src_port_odd, 1'b1}, '{src_temp, src_agnd, 1'b0},
        '{src_agnd, src_agnd, 1'b0}, '{src_port_even, src_agnd, 1'b0}, '{src_ain1, src_agnd, 1'b0},
        '{src_hv_amp, src_hv_ref, 1'b1}};

    adc_input_mux_config uut (.clk(clk), .reset(reset), .sfr(sfr), .sfr_rdata_q(rdata_q),
        .sfr_read_valid_q(rvalid_q), .conv_done(conv_done), .conv_raw(conv_raw), .subsystem_on_q(on_q),
        .conv_start_q(start_q), .route_q(route_q), .gain_q(gain_q), .even_pins_q(epins_q), .odd_pins_q(opins_q),
        .even_wired_or_q(ewor_q), .odd_wired_or_q(owor_q), .result_q(result_q), .result_valid_q(rsvalid_q));

    always #12.5 clk = ~clk;

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 sfr = '{a, 1'b1, 1'b0, d};
        @(posedge clk);
        #1 sfr = '0;
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input logic v);
        @(posedge clk);
        #1 sfr = '{a, 1'b0, 1'b1, 8'h00};
        @(posedge clk);
        #1 sfr = '0;
        chk({rvalid_q, rdata_q}, {v, exp});
    endtask : rdchk
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle
    task automatic convert(input logic [11:0] raw, input logic [11:0] exp);
        conv_raw = raw;
        conv_done = 1'b1;
        @(posedge clk);
        #1 conv_done = 1'b0;
        chk({rsvalid_q, result_q}, {1'b1, exp});
    endtask : convert
    task automatic final_report;
        if (failures == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    initial begin
        #200000;
        failures++;
        final_report();
    end

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        #1 reset = 1'b0;
        chk(route_q, {src_ain0, src_agnd, 1'b0});
        chk(gain_q, gain_unity);
        rdchk(8'hBA, 8'h00, 1'b1);
        rdchk(8'hBC, 8'h00, 1'b0);
        wr(8'hBA, 8'hFF);
        rdchk(8'hBA, 8'h0F, 1'b1);
        for (int i = 0; i < 8; i++) begin
            wr(8'hB9, {5'h00, gcode[i]});
            idle(2);
            chk(gain_q, gexp[i]);
        end
        for (int i = 0; i < 12; i++) begin
            wr(8'hBA, rcfg[i]);
            wr(8'hBB, rch[i]);
            idle(2);
            chk(route_q, rexp[i]);
        end
        wr(8'hBD, 8'h55);
        idle(2);
        chk({epins_q, opins_q, ewor_q, owor_q}, {4'hF, 4'h0, 1'b1, 1'b0});
        wr(8'hBD, 8'h06);
        idle(2);
        chk({epins_q, opins_q, ewor_q, owor_q}, {4'h2, 4'h1, 1'b0, 1'b0});
        wr(8'hB8, 8'h10);
        chk(start_q, 1'b0);
        wr(8'hBA, 8'h01);
        wr(8'hBB, 8'h00);
        wr(8'hB8, 8'h90);
        chk({on_q, start_q}, 2'b11);
        wr(8'hBA, 8'h00);
        idle(1);
        chk(route_q.diff, 1'b1);
        convert(12'h123, 12'h923);
        rdchk(8'hB8, 8'hA0, 1'b1);
        idle(2);
        chk(route_q.diff, 1'b0);
        wr(8'hB8, 8'h90);
        idle(1);
        convert(12'hABC, 12'hABC);
        wr(8'hB8, 8'h00);
        idle(2);
        chk(on_q, 1'b0);
        final_report();
    end
endmodule : adc_input_mux_config_bench
